// [design/dsram_pkg.sv]
// Shared constants of the double-data-rate split-port SRAM access logic
package dsram_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int DSRAM_ADDR_W  = 18;
  localparam int DSRAM_DATA_W  = 18;
  localparam int DSRAM_LANE_W  = 9;
  localparam int DSRAM_LANES   = 2;
  localparam int DSRAM_WORD_W  = 2 * DSRAM_DATA_W;
  localparam int DSRAM_WLANES  = 2 * DSRAM_LANES;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic DSRAM_SEL_RST   = 1'h1;
  localparam logic DSRAM_MASK_RST  = 1'h1;
  localparam logic DSRAM_KPOS_RST  = 1'h0;
  localparam logic DSRAM_KNEG_RST  = 1'h1;
  localparam logic DSRAM_OE_RST    = 1'h0;
  localparam logic DSRAM_RDY_RST   = 1'h1;

  // ---------------------------------------------------------------------------
  // Controller read return taps, counted from the edge a read is taken
  // ---------------------------------------------------------------------------
  localparam int DSRAM_RD_SH_W   = 5;
  localparam int DSRAM_RD_LO_TAP = 3;
  localparam int DSRAM_RD_HI_TAP = 4;

endpackage

// [design/dsram_if.sv]
// Pin bundle between the memory controller and the SRAM access logic
`timescale 1ns/100ps

interface dsram_if;
  import dsram_pkg::*;

  logic                    k_clk;
  logic                    k_clk_n;
  logic                    c_clk;
  logic                    c_clk_n;
  logic                    read_port_select_n;
  logic                    wr_port_sel_n;
  logic                    lane0_wr_mask_n;
  logic                    lane1_wr_mask_n;
  logic [DSRAM_ADDR_W-1:0] addr;
  logic [DSRAM_DATA_W-1:0] d;
  logic [DSRAM_DATA_W-1:0] q;
  logic                    q_oe;

  modport dev (
    input  k_clk, k_clk_n, c_clk, c_clk_n, read_port_select_n, wr_port_sel_n,
    input  lane0_wr_mask_n, lane1_wr_mask_n, addr, d,
    output q, q_oe
  );

  modport ctl (
    output k_clk, k_clk_n, c_clk, c_clk_n, read_port_select_n, wr_port_sel_n,
    output lane0_wr_mask_n, lane1_wr_mask_n, addr, d,
    input  q, q_oe
  );

endinterface

// [design/dsram_dev.sv]
// Device end: split-port SRAM with two-word DDR bursts on one address bus
`timescale 1ns/100ps

module dsram_dev
  import dsram_pkg::*;
#(
  parameter int MEM_AW = DSRAM_ADDR_W
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  dsram_if.dev      bus,
  output logic      single_clk_mode,
  output logic      wr_commit
);

  // ---------------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------------
  if (MEM_AW < 1 || MEM_AW > DSRAM_ADDR_W) begin : g_bad_aw
    $error("MEM_AW must lie between 1 and the address bus width");
  end

  localparam int DEPTH = 1 << MEM_AW;

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [DSRAM_WORD_W-1:0] mem [DEPTH];

  logic                    single_r;
  logic                    strap_done_r;
  logic [MEM_AW-1:0]       rd_addr_r;
  logic                    rd_pend_r;
  logic [DSRAM_DATA_W-1:0] hi_word_r;
  logic                    hi_pend_r;
  logic [DSRAM_DATA_W-1:0] q_r;
  logic                    q_oe_r;
  logic                    wr_pend_r;
  logic [DSRAM_DATA_W-1:0] wr_lo_r;
  logic [DSRAM_DATA_W-1:0] wr_hi_r;
  logic [DSRAM_LANES-1:0]  wr_lo_en_r;
  logic [MEM_AW-1:0]       wr_addr_r;
  logic                    wr_commit_r;

  wire                     k_pos;
  wire                     k_neg;
  wire                     out_pos;
  wire                     out_neg;
  wire                     rd_go;
  wire                     wr_go;
  wire                     wr_done;
  wire                     hi_done;
  wire [DSRAM_LANES-1:0]   lane_en;
  wire [MEM_AW-1:0]        bus_addr;
  wire [DSRAM_WORD_W-1:0]  rd_word;
  wire [DSRAM_WORD_W-1:0]  old_word;
  wire [DSRAM_WORD_W-1:0]  new_word;
  wire [DSRAM_DATA_W-1:0]  lo_nxt;
  wire [DSRAM_DATA_W-1:0]  hi_nxt;
  wire [DSRAM_WLANES-1:0]  commit_en;

  // ---------------------------------------------------------------------------
  // Clock phases and decode
  // ---------------------------------------------------------------------------
  // Both K phases arrive as levels sampled on clk_sys; a high level marks a rise
  assign k_pos    = bus.k_clk;
  assign k_neg    = bus.k_clk_n;
  // Single mode lets the input pair launch outputs too
  assign out_pos  = single_r ? bus.k_clk   : bus.c_clk;
  assign out_neg  = single_r ? bus.k_clk_n : bus.c_clk_n;

  // Selects are looked at on the positive K rise only
  assign rd_go    = k_pos & ~bus.read_port_select_n;
  assign wr_go    = k_pos & ~bus.wr_port_sel_n;
  assign wr_done  = k_neg & wr_pend_r;
  assign hi_done  = out_neg & hi_pend_r;

  assign lane_en  = {~bus.lane1_wr_mask_n, ~bus.lane0_wr_mask_n};
  assign bus_addr = bus.addr[MEM_AW-1:0];

  // Array is read after any write committed on the negative edge between, so a
  // write started with the read at the same address is already visible
  assign rd_word  = mem[rd_addr_r];
  assign old_word = mem[bus_addr];

  // ---------------------------------------------------------------------------
  // Byte-lane merge
  // ---------------------------------------------------------------------------
  for (genvar j = 0; j < DSRAM_LANES; j++) begin : g_lane
    localparam int LO = j * DSRAM_LANE_W;
    localparam int HI = LO + DSRAM_LANE_W - 1;

    // A disabled lane keeps what the buffer already holds
    assign lo_nxt[HI:LO] = lane_en[j] ? bus.d[HI:LO] : wr_lo_r[HI:LO];
    assign hi_nxt[HI:LO] = lane_en[j] ? bus.d[HI:LO] : wr_hi_r[HI:LO];

    // Only enabled lanes of each half reach the array; both off is a no-op
    assign commit_en[j]               = wr_lo_en_r[j];
    assign commit_en[j + DSRAM_LANES] = lane_en[j];
  end

  for (genvar w = 0; w < DSRAM_WLANES; w++) begin : g_word
    localparam int LO = w * DSRAM_LANE_W;
    localparam int HI = LO + DSRAM_LANE_W - 1;
    localparam int HB = (w % DSRAM_LANES) * DSRAM_LANE_W;
    localparam int HT = HB + DSRAM_LANE_W - 1;

    if (w < DSRAM_LANES) begin : g_lo
      assign new_word[HI:LO] = commit_en[w] ? wr_lo_r[HT:HB] : old_word[HI:LO];
    end else begin : g_hi
      assign new_word[HI:LO] = commit_en[w] ? bus.d[HT:HB] : old_word[HI:LO];
    end
  end

  // ---------------------------------------------------------------------------
  // Clock mode strap
  // ---------------------------------------------------------------------------
  // Caught once after reset release; the mode must not change while running
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      single_r     <= 1'h0;
      strap_done_r <= 1'h0;
    end else if (!strap_done_r) begin
      single_r     <= bus.c_clk & bus.c_clk_n;
      strap_done_r <= 1'h1;
    end
  end

  // ---------------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_addr_r <= '0;
      rd_pend_r <= 1'h0;
    end else if (k_pos) begin
      rd_pend_r <= rd_go;
      if (rd_go) begin
        rd_addr_r <= bus_addr;
      end
    end
  end

  // Pending burst always finishes before the drivers turn off
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q_r       <= '0;
      q_oe_r    <= DSRAM_OE_RST;
      hi_word_r <= '0;
      hi_pend_r <= 1'h0;
    end else if (out_pos) begin
      hi_pend_r <= rd_pend_r;
      if (rd_pend_r) begin
        q_r       <= rd_word[DSRAM_DATA_W-1:0];
        hi_word_r <= rd_word[DSRAM_WORD_W-1:DSRAM_DATA_W];
        q_oe_r    <= 1'h1;
      end else begin
        q_oe_r    <= 1'h0;
      end
    end else if (hi_done) begin
      q_r       <= hi_word_r;
      hi_pend_r <= 1'h0;
    end
  end

  // ---------------------------------------------------------------------------
  // Write port
  // ---------------------------------------------------------------------------
  // A deselected rise leaves wr_pend_r low, so the following negative rise
  // is ignored as well
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_pend_r  <= 1'h0;
      wr_lo_r    <= '0;
      wr_lo_en_r <= '0;
    end else if (k_pos) begin
      wr_pend_r  <= wr_go;
      if (wr_go) begin
        wr_lo_r    <= lo_nxt;
        wr_lo_en_r <= lane_en;
      end
    end else if (k_neg) begin
      wr_pend_r  <= 1'h0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_addr_r   <= '0;
      wr_hi_r     <= '0;
      wr_commit_r <= 1'h0;
    end else begin
      wr_commit_r <= wr_done;
      if (wr_done) begin
        wr_addr_r <= bus_addr;
        wr_hi_r   <= hi_nxt;
      end
    end
  end

  // Array has no reset; its contents are undefined until written
  always_ff @(posedge clk_sys) begin
    if (wr_done) begin
      mem[bus_addr] <= new_word;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign bus.q           = q_r;
  assign bus.q_oe        = q_oe_r;
  assign single_clk_mode = single_r;
  assign wr_commit       = wr_commit_r;

endmodule

// [design/dsram_ctl.sv]
// Controller end: drives clocks, selects, address and burst data to the SRAM
`timescale 1ns/100ps

module dsram_ctl
  import dsram_pkg::*;
#(
  parameter bit SINGLE_CLK = 1'b0
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  dsram_if.ctl                         bus,
  output logic                         cmd_rdy,
  input  wire logic                    rd_req,
  input  wire logic [DSRAM_ADDR_W-1:0] rd_addr,
  input  wire logic                    wr_req,
  input  wire logic [DSRAM_ADDR_W-1:0] wr_addr,
  input  wire logic [DSRAM_WORD_W-1:0] wr_data,
  input  wire logic [DSRAM_WLANES-1:0] wr_lane_en,
  output logic [DSRAM_WORD_W-1:0]      rd_data,
  output logic                         rd_valid
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic                     k_r;
  logic                     k_n_r;
  logic                     rdy_r;
  logic                     rsel_n_r;
  logic                     wsel_n_r;
  logic [DSRAM_LANES-1:0]   mask_n_r;
  logic [DSRAM_ADDR_W-1:0]  addr_r;
  logic [DSRAM_DATA_W-1:0]  d_r;
  logic [DSRAM_ADDR_W-1:0]  wr_addr_h_r;
  logic [DSRAM_DATA_W-1:0]  wr_hi_h_r;
  logic [DSRAM_LANES-1:0]   hi_en_h_r;
  logic [DSRAM_RD_SH_W-1:0] rd_sh_r;
  logic [DSRAM_DATA_W-1:0]  lo_cap_r;
  logic [DSRAM_WORD_W-1:0]  rd_data_r;
  logic                     rd_valid_r;

  wire                      take;
  wire                      c_pos;
  wire                      c_neg;

  assign take  = rdy_r & (rd_req | wr_req);
  // Single mode ties both output clocks high so the device senses it at power-up
  assign c_pos = SINGLE_CLK ? 1'b1 : k_r;
  assign c_neg = SINGLE_CLK ? 1'b1 : k_n_r;

  // ---------------------------------------------------------------------------
  // Free-running K pair, new command on each positive rise
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      k_r      <= DSRAM_KPOS_RST;
      k_n_r    <= DSRAM_KNEG_RST;
      rdy_r    <= DSRAM_RDY_RST;
      rsel_n_r <= DSRAM_SEL_RST;
      wsel_n_r <= DSRAM_SEL_RST;
      mask_n_r <= {DSRAM_LANES{DSRAM_MASK_RST}};
      addr_r   <= '0;
      d_r      <= '0;
    end else if (rdy_r) begin
      k_r      <= 1'h1;
      k_n_r    <= 1'h0;
      rdy_r    <= 1'h0;
      rsel_n_r <= ~rd_req;
      wsel_n_r <= ~wr_req;
      mask_n_r <= ~wr_lane_en[DSRAM_LANES-1:0];
      addr_r   <= rd_addr;
      d_r      <= wr_data[DSRAM_DATA_W-1:0];
    end else begin
      k_r      <= 1'h0;
      k_n_r    <= 1'h1;
      rdy_r    <= 1'h1;
      rsel_n_r <= DSRAM_SEL_RST;
      wsel_n_r <= DSRAM_SEL_RST;
      mask_n_r <= ~hi_en_h_r;
      addr_r   <= wr_addr_h_r;
      d_r      <= wr_hi_h_r;
    end
  end

  // Second half of a write is held for the negative rise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_addr_h_r <= '0;
      wr_hi_h_r   <= '0;
      hi_en_h_r   <= '0;
    end else if (rdy_r) begin
      wr_addr_h_r <= wr_addr;
      wr_hi_h_r   <= wr_data[DSRAM_WORD_W-1:DSRAM_DATA_W];
      hi_en_h_r   <= wr_req ? wr_lane_en[DSRAM_WLANES-1:DSRAM_LANES] : '0;
    end
  end

  // ---------------------------------------------------------------------------
  // Read return
  // ---------------------------------------------------------------------------
  // Fixed latency tracking; relies on the output clocks aligned with K
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_sh_r    <= '0;
      lo_cap_r   <= '0;
      rd_data_r  <= '0;
      rd_valid_r <= 1'h0;
    end else begin
      rd_sh_r    <= {rd_sh_r[DSRAM_RD_SH_W-2:0], rdy_r & rd_req};
      rd_valid_r <= rd_sh_r[DSRAM_RD_HI_TAP];
      if (rd_sh_r[DSRAM_RD_LO_TAP]) begin
        lo_cap_r <= bus.q;
      end
      if (rd_sh_r[DSRAM_RD_HI_TAP]) begin
        rd_data_r <= {bus.q, lo_cap_r};
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign bus.k_clk              = k_r;
  assign bus.k_clk_n            = k_n_r;
  assign bus.c_clk              = c_pos;
  assign bus.c_clk_n            = c_neg;
  assign bus.read_port_select_n = rsel_n_r;
  assign bus.wr_port_sel_n      = wsel_n_r;
  assign bus.lane0_wr_mask_n    = mask_n_r[0];
  assign bus.lane1_wr_mask_n    = mask_n_r[1];
  assign bus.addr               = addr_r;
  assign bus.d                  = d_r;
  assign cmd_rdy                = rdy_r;
  assign rd_data                = rd_data_r;
  assign rd_valid               = rd_valid_r;

endmodule

// [tb/dsram_props.sv]
// Checker of the pin protocol between the controller end and the SRAM end
`timescale 1ns/100ps

module dsram_props
  import dsram_pkg::*;
(
  input wire logic                    clk_sys,
  input wire logic                    rst,
  input wire logic                    k_clk,
  input wire logic                    k_clk_n,
  input wire logic                    c_clk,
  input wire logic                    c_clk_n,
  input wire logic                    read_port_select_n,
  input wire logic                    wr_port_sel_n,
  input wire logic                    lane0_wr_mask_n,
  input wire logic                    lane1_wr_mask_n,
  input wire logic [DSRAM_ADDR_W-1:0] addr,
  input wire logic [DSRAM_DATA_W-1:0] d,
  input wire logic [DSRAM_DATA_W-1:0] q,
  input wire logic                    q_oe
);
  // ---------------------------------------------------------------------------
  // Pin timing
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_rd;
    k_clk && !read_port_select_n;
  endsequence

  property p_k_toggle;
    k_clk |=> !k_clk;
  endproperty
  a_k_toggle: assert property (p_k_toggle) else $error("k_clk high two cycles");

  property p_k_comp;
    k_clk_n == !k_clk;
  endproperty
  a_k_comp: assert property (p_k_comp) else $error("k clock pair not opposite");

  property p_c_align;
    (c_clk && c_clk_n) || (c_clk == k_clk && c_clk_n == k_clk_n);
  endproperty
  a_c_align: assert property (p_c_align) else $error("output clocks neither tied nor aligned");

  property p_oe_rise;
    s_rd |-> ##3 q_oe ##1 q_oe;
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("read burst not driven");

  property p_oe_cause;
    $rose(q_oe) |-> $past(k_clk && !read_port_select_n, 3);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("outputs enabled without read");

  property p_hiz;
    s_rd ##2 read_port_select_n |-> ##3 !q_oe;
  endproperty
  a_hiz: assert property (p_hiz) else $error("outputs not three-stated after burst");

  property p_pipe;
    s_rd ##2 s_rd |-> ##1 q_oe [*4];
  endproperty
  a_pipe: assert property (p_pipe) else $error("back-to-back reads broke drive");

  property p_fall;
    $fell(q_oe) |-> !$past(k_clk && !read_port_select_n, 3) &&
                    !$past(k_clk && !read_port_select_n, 4);
  endproperty
  a_fall: assert property (p_fall) else $error("outputs dropped during a burst");

  property p_sel_k;
    !k_clk |-> read_port_select_n && wr_port_sel_n;
  endproperty
  a_sel_k: assert property (p_sel_k) else $error("select driven off the positive rise");

  property p_q_idle;
    !q_oe |=> q_oe || $stable(q);
  endproperty
  a_q_idle: assert property (p_q_idle) else $error("read data moved while three-stated");

  c_rd:   cover property (s_rd);
  c_b2b:  cover property (s_rd ##2 s_rd);
  c_wr:   cover property (k_clk && !wr_port_sel_n);
  c_fall: cover property ($fell(q_oe));
endmodule

// [tb/ddr_split_port_sram_access_test.sv]
// Self-checking bench: controller and SRAM ends joined, random and corner traffic
`timescale 1ns/100ps

module ddr_split_port_sram_access_test;
  import dsram_pkg::*;
  // ---------------------------------------------------------------------------
  // Bench state
  // ---------------------------------------------------------------------------
  logic                    clk_sys = 1'b0;
  logic                    rst = 1'b1;
  logic                    rd_req = 1'b0;
  logic                    wr_req = 1'b0;
  logic [DSRAM_ADDR_W-1:0] rd_addr = '0;
  logic [DSRAM_ADDR_W-1:0] wr_addr = '0;
  logic [DSRAM_WORD_W-1:0] wr_data = '0;
  logic [DSRAM_WLANES-1:0] wr_lane_en = '0;
  logic                    cmd_rdy;
  logic [DSRAM_WORD_W-1:0] rd_data;
  logic                    rd_valid;
  logic                    single_clk_mode;
  logic                    wr_commit;
  logic [DSRAM_WORD_W-1:0] rd_data_s;
  logic                    rd_valid_s;
  logic                    single_clk_mode_s;
  int                      exp_wc [$];
  logic [DSRAM_WORD_W-1:0] mem_model [0:63];
  logic [DSRAM_WORD_W-1:0] exp_q [$];
  int                      exp_cyc [$];
  int                      n_errors = 0;
  int                      samples_checked = 0;
  int                      cyc = 0;
  int                      seed = 75;
  logic [5:0]              last_rd = 6'h3f;
  logic [7:0]              rd_hist = '0;

  // Short memory window keeps the model small and the fill quick
  dsram_if bus ();
  dsram_if bus_s ();
  dsram_dev #(.MEM_AW(6)) dsram_dev_inst (.clk_sys(clk_sys), .rst(rst), .bus(bus.dev),
    .single_clk_mode(single_clk_mode), .wr_commit(wr_commit));
  // Second pair runs the same traffic with both output clocks tied high
  dsram_dev #(.MEM_AW(6)) dsram_dev_single_inst (.clk_sys(clk_sys), .rst(rst),
    .bus(bus_s.dev), .single_clk_mode(single_clk_mode_s), .wr_commit());
  dsram_ctl #(.SINGLE_CLK(1'b1)) dsram_ctl_single_inst (.clk_sys(clk_sys), .rst(rst),
    .bus(bus_s.ctl), .cmd_rdy(), .rd_req(rd_req), .rd_addr(rd_addr), .wr_req(wr_req),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_lane_en(wr_lane_en), .rd_data(rd_data_s),
    .rd_valid(rd_valid_s));
  dsram_ctl #(.SINGLE_CLK(1'b0)) dsram_ctl_inst (.clk_sys(clk_sys), .rst(rst), .bus(bus.ctl),
    .cmd_rdy(cmd_rdy), .rd_req(rd_req), .rd_addr(rd_addr), .wr_req(wr_req),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_lane_en(wr_lane_en), .rd_data(rd_data),
    .rd_valid(rd_valid));
  dsram_props dsram_props_inst (.clk_sys(clk_sys), .rst(rst), .k_clk(bus.k_clk),
    .k_clk_n(bus.k_clk_n), .c_clk(bus.c_clk), .c_clk_n(bus.c_clk_n),
    .read_port_select_n(bus.read_port_select_n), .wr_port_sel_n(bus.wr_port_sel_n),
    .lane0_wr_mask_n(bus.lane0_wr_mask_n), .lane1_wr_mask_n(bus.lane1_wr_mask_n),
    .addr(bus.addr), .d(bus.d), .q(bus.q), .q_oe(bus.q_oe));

  always #4 clk_sys = ~clk_sys;

  // Random draws, cut on purpose to the width a field needs
  function automatic logic [31:0] rnd32();
    return $random(seed);
  endfunction

  function automatic logic [DSRAM_WORD_W-1:0] rnd_word();
    logic [63:0] r;
    r = {rnd32(), rnd32()};
    return r[DSRAM_WORD_W-1:0];
  endfunction

  // Lane-gated merge: a lane whose enable is low keeps the old bits
  function automatic logic [DSRAM_WORD_W-1:0] merge(input logic [DSRAM_WORD_W-1:0] old_w,
      input logic [DSRAM_WORD_W-1:0] new_w, input logic [DSRAM_WLANES-1:0] en);
    logic [DSRAM_WORD_W-1:0] r;
    r = old_w;
    for (int j = 0; j < DSRAM_WLANES; j++) begin
      if (en[j]) r[j*DSRAM_LANE_W +: DSRAM_LANE_W] = new_w[j*DSRAM_LANE_W +: DSRAM_LANE_W];
    end
    return r;
  endfunction

  task automatic report_and_stop();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic fail(input string msg);
    n_errors++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask

  // One cycle: step past the edge, then look at the returned data and the pin
  task automatic tick();
    logic [DSRAM_WORD_W-1:0] e;
    logic                    exp_oe;
    @(posedge clk_sys);
    #1;
    cyc++;
    rd_hist = {rd_hist[6:0], 1'b0};
    // A burst holds the pins two cycles, from the fourth tick after its slot
    exp_oe = rd_hist[4] | rd_hist[5];
    samples_checked++;
    if (bus.q_oe !== exp_oe) fail("read data drive wrong");
    if (bus_s.q_oe !== exp_oe) fail("single clock drive wrong");
    if (rd_valid_s !== rd_hist[6]) fail("single clock read return wrong");
    if (rd_valid === 1'b1) begin
      samples_checked++;
      if (exp_q.size() == 0) fail("read data with no read pending");
      else begin
        e = exp_q.pop_front();
        if (rd_data !== e) fail("read data wrong");
        if (rd_data_s !== e) fail("single clock read data wrong");
        if (cyc - exp_cyc.pop_front() != 6) fail("read latency wrong");
      end
    end
    if (wr_commit === 1'b1) begin
      samples_checked++;
      if (exp_wc.size() == 0) fail("write committed with no write pending");
      else if (cyc - exp_wc.pop_front() != 3) fail("write commit timing wrong");
    end
  endtask

  // Issue one slot; a slot with neither request leaves both ports deselected
  task automatic do_op(input logic rr, input logic [5:0] ra, input logic wr,
      input logic [5:0] wa, input logic [DSRAM_WORD_W-1:0] wd, input logic [3:0] we);
    int n;
    tick();
    rd_req = 1'b0;
    wr_req = 1'b0;
    n = 0;
    while (cmd_rdy !== 1'b1) begin
      n++;
      if (n > 4) begin
        fail("cmd_rdy never returned");
        report_and_stop();
      end
      tick();
    end
    rd_req = rr;
    rd_addr = {12'h000, ra};
    wr_req = wr;
    wr_addr = {12'h000, wa};
    wr_data = wd;
    wr_lane_en = we;
    if (wr) begin
      mem_model[wa] = merge(mem_model[wa], wd, we);
      exp_wc.push_back(cyc);
    end
    if (rr) begin
      exp_q.push_back(mem_model[ra]);
      exp_cyc.push_back(cyc);
      rd_hist[0] = 1'b1;
    end
  endtask

  initial begin
    logic [5:0]              a;
    logic [5:0]              b;
    logic [31:0]             r;
    logic [DSRAM_WORD_W-1:0] v;
    repeat (2) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    tick();
    samples_checked++;
    if (single_clk_mode !== 1'b0) fail("clock mode strap wrong");
    samples_checked++;
    if (single_clk_mode_s !== 1'b1) fail("single clock strap wrong");
    for (int i = 0; i < 64; i++) begin
      do_op(1'b0, 6'h00, 1'b1, i[5:0], rnd_word(), 4'hf);
    end
    // Every lane pattern on one word, then reads back to back with writes
    for (int i = 0; i < 16; i++) begin
      do_op(1'b1, 6'h05, 1'b1, 6'h05, rnd_word(), i[3:0]);
    end
    do_op(1'b1, 6'h05, 1'b0, 6'h00, '0, 4'hf);
    for (int i = 0; i < 400; i++) begin
      r = rnd32();
      a = r[5:0];
      r = rnd32();
      b = r[5:0];
      v = rnd_word();
      // Write after a read to the same word has no coherency promise
      if (b == last_rd) b = b ^ 6'h01;
      r = rnd32();
      do_op(r[0], a, r[1], b, v, r[5:2]);
      last_rd = rd_req ? a : 6'h3f;
    end
    do_op(1'b0, 6'h00, 1'b0, 6'h00, '0, 4'h0);
    repeat (10) tick();
    samples_checked++;
    if (exp_q.size() != 0) fail("reads never returned");
    samples_checked++;
    if (exp_wc.size() != 0) fail("writes never committed");
    report_and_stop();
  end
endmodule
